// file: inc/temp_result_pkg.sv
// Shared constants and carrier types of the temperature result block.
package temp_result_pkg;

  // Register addresses as seen through the write-loaded pointer.
  localparam logic [7:0] ADDR_TEMP_RESULT = 8'h00;
  localparam logic [7:0] ADDR_CONFIG_RD = 8'h03;
  localparam logic [7:0] ADDR_RATE_RD = 8'h04;
  localparam logic [7:0] ADDR_CONFIG_WR = 8'h09;
  localparam logic [7:0] ADDR_RATE_WR = 8'h0a;
  localparam logic [7:0] ADDR_ONE_SHOT = 8'h0f;

  // Reset values and the value read at an unmapped address.
  localparam logic [7:0] RST_TEMP_RESULT = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h08;
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Configuration field positions.
  localparam int CFG_RANGE_BIT = 2;
  localparam int CFG_PIN_FUNC_BIT = 5;
  localparam int CFG_STANDBY_BIT = 6;
  localparam int CFG_MASK_BIT = 7;

  // Conversion rate codes.
  localparam logic [3:0] RATE_CODE_MAX = 4'ha;
  localparam logic [3:0] RATE_FIRST_UNAVERAGED = 4'h8;

  // Result formatting.
  localparam int MEAS_WIDTH = 10;
  localparam int OFFSET_DEG = 64;
  localparam int BINARY_MAX = 127;
  localparam int OFFSET_CODE_MAX = 255;
  localparam int AVG_COUNT = 16;
  localparam int AVG_SHIFT = 4;

  // Longest conversion interval, code 0, and the clock rate.
  localparam longint CONV_PERIOD_MAX_S = 16;
  localparam longint REF_CLK_HZ = 20_000_000;
  localparam longint CONV_PERIOD_MAX_CYC = CONV_PERIOD_MAX_S * REF_CLK_HZ;

  // One byte presented by the serial front end.
  typedef struct packed {
    logic wr;
    logic first;
    logic [7:0] data;
  } link_byte_type;

  // One raw measurement from the analogue path.
  typedef struct packed {
    logic done;
    logic signed [MEAS_WIDTH-1:0] deg;
  } meas_type;

endpackage : temp_result_pkg

// file: verilog/temp_result_config_regs.sv
// Result formatting, pointer and configuration registers of the monitor.
`timescale 1ns/10ps

// What this block does
// - Latest result held at address 0x00, 1 degree LSB
// - Config bit 2 selects default or extended range
// - New range takes effect at next conversion
// - Default range clamps to 0 through 127
// - Extended range stores temperature plus 64
// - Extended code spans minus 64 to 191
// - Range change reformats results, limits untouched
// - First write byte loads pointer, second writes
// - Pointer resets to 0x00, reads temperature
// - Temperature register read-only, resets to 0x00
// - Config read 0x03, written 0x09, reset 0x00
// - Bit 7 masks alarm, only in alarm mode
// - Bit 6 stops conversions, standby
// - Register access works during standby
// - Alarm outputs live and updated in standby
// - Bit 5 selects alarm or second shutdown
// - Rate read 0x04, written 0x0A, low nibble
// - Interval is oscillator divided by power of two
// - Rate resets to 0x08, sixteen per second
// - One conversion starts each interval while running
// - Average sixteen measurements at slow rates
// - Write to 0x0F in standby converts once
module temp_result_config_regs
  import temp_result_pkg::*;
#(
  parameter longint CONV_PERIOD_CYC = CONV_PERIOD_MAX_CYC,
  parameter int CNT_WIDTH = 29
)
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic LINK_CLK,
  input wire link_byte_type LINK_IN,
  output logic [7:0] LINK_RDATA,
  output logic MEAS_START,
  input wire meas_type MEAS_IN,
  input wire logic ALERT_COND,
  input wire logic HIGH_COND,
  input wire logic OVERTEMP_COND,
  output logic ALARM_PIN_N,
  output logic OVERTEMP_SHUTDOWN_N,
  output logic CONV_BUSY,
  output logic RANGE_EXTENDED
);

  // IDLE waits for a tick or a one-shot, LAUNCH issues one request, and
  // WAIT_MEAS holds until the analogue path answers it.
  typedef enum logic [1:0] {IDLE, LAUNCH, WAIT_MEAS} conv_state_type;

  // Sixteen signed readings need four guard bits above one reading.
  localparam int SUM_WIDTH = MEAS_WIDTH + AVG_SHIFT;

  // Two flip-flop synchronisers for everything the link side drives.
  logic link_clk_s1_q, link_clk_s2_q, link_clk_s3_q;
  link_byte_type link_s1_q, link_s2_q;
  logic link_edge;

  // Bus-visible registers and the pending one-shot request.
  logic [7:0] pointer_q;
  logic [7:0] temp_result_q;
  logic [7:0] config_q;
  logic [7:0] rate_q;
  logic one_shot_q;

  // Conversion interval divider.
  logic [CNT_WIDTH-1:0] interval_cnt_q;
  logic interval_tick;
  logic [3:0] rate_code;
  logic [CNT_WIDTH-1:0] interval_len;

  // Sequencer state and the running sum of one averaged result.
  conv_state_type state_q;
  logic range_latched_q;
  logic [4:0] meas_left_q;
  logic [4:0] meas_total_q;
  logic signed [SUM_WIDTH-1:0] sum_q;
  logic signed [SUM_WIDTH-1:0] sum_next;
  logic signed [MEAS_WIDTH-1:0] avg_deg;

  // Decoded strobes shared by several registers.
  logic wr_data_byte;
  logic standby;

  // Link clock and byte fields are both synchronised, then the rising
  // edge is found on the second stage against a third, edge-only stage.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      link_clk_s1_q <= 1'b0;
      link_clk_s2_q <= 1'b0;
      link_clk_s3_q <= 1'b0;
      link_s1_q <= '0;
      link_s2_q <= '0;
    end
    else
    begin
      link_clk_s1_q <= LINK_CLK;
      link_clk_s2_q <= link_clk_s1_q;
      link_clk_s3_q <= link_clk_s2_q;
      link_s1_q <= LINK_IN;
      link_s2_q <= link_s1_q;
    end
  end

  // Data lags nothing behind the clock: both pass the same two stages.
  assign link_edge = link_clk_s2_q & ~link_clk_s3_q;
  assign wr_data_byte = link_edge & link_s2_q.wr & ~link_s2_q.first;
  assign standby = config_q[CFG_STANDBY_BIT];

  // The first byte of every write lands in the pointer.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      pointer_q <= RST_POINTER;
    else if (link_edge && link_s2_q.wr && link_s2_q.first)
      pointer_q <= link_s2_q.data;
  end

  // Configuration register; the serial side stays live in standby.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      config_q <= RST_CONFIG;
    else if (wr_data_byte && pointer_q == ADDR_CONFIG_WR)
      config_q <= link_s2_q.data;
  end

  // Rate register keeps the whole byte so software reads back its write.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rate_q <= RST_RATE;
    else if (wr_data_byte && pointer_q == ADDR_RATE_WR)
      rate_q <= link_s2_q.data;
  end

  // A one-shot request is held until the sequencer takes it; the written
  // data itself is thrown away.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      one_shot_q <= 1'b0;
    else if (wr_data_byte && pointer_q == ADDR_ONE_SHOT && standby)
      one_shot_q <= 1'b1;
    else if (state_q == IDLE)
      one_shot_q <= 1'b0;
  end

  // Read data follows the pointer every cycle, so a read needs no request.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      LINK_RDATA <= RST_TEMP_RESULT;
    else
    begin
      unique case (pointer_q)
        ADDR_TEMP_RESULT: LINK_RDATA <= temp_result_q;
        ADDR_CONFIG_RD: LINK_RDATA <= config_q;
        ADDR_RATE_RD: LINK_RDATA <= rate_q;
        default: LINK_RDATA <= UNMAPPED_READ;
      endcase
    end
  end

  // Reserved codes above the top rate run at the top rate; the upper
  // nibble is never looked at.
  assign rate_code = (rate_q[3:0] > RATE_CODE_MAX) ? RATE_CODE_MAX
                                                    : rate_q[3:0];
  assign interval_len = CNT_WIDTH'(CONV_PERIOD_CYC >> rate_code);
  assign interval_tick = (interval_cnt_q == '0);

  // Interval divider; it stops in standby and, because it rests at zero,
  // a conversion starts at once on wake.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      interval_cnt_q <= '0;
    else if (standby)
      interval_cnt_q <= '0;
    else if (interval_tick)
      interval_cnt_q <= interval_len - 1'b1;
    // A rate change that shortens the interval pulls the count in at
    // once, so the new rate shows within one interval.
    else if (interval_cnt_q >= interval_len)
      interval_cnt_q <= interval_len - 1'b1;
    else
      interval_cnt_q <= interval_cnt_q - 1'b1;
  end

  // Running sum and its floor average; the arithmetic shift rounds toward
  // minus infinity, so an average of -0.5 degrees reads as -1.
  assign sum_next = sum_q + SUM_WIDTH'(MEAS_IN.deg);
  assign avg_deg = MEAS_WIDTH'(sum_next >>> AVG_SHIFT);

  // Clamp and offset one averaged temperature into the stored code.
  function automatic logic [7:0] format_result(
    input logic signed [MEAS_WIDTH-1:0] deg,
    input logic extended
  );
    // Two spare bits keep the offset sum from wrapping.
    logic signed [MEAS_WIDTH+1:0] v;
    v = (MEAS_WIDTH+2)'(deg);
    if (extended)
    begin
      v = v + (MEAS_WIDTH+2)'(OFFSET_DEG);
      if (v < 0)
        format_result = 8'h00;
      else if (v > (MEAS_WIDTH+2)'(OFFSET_CODE_MAX))
        format_result = 8'hff;
      else
        format_result = v[7:0];
    end
    else
    begin
      if (v < 0)
        format_result = 8'h00;
      else if (v > (MEAS_WIDTH+2)'(BINARY_MAX))
        format_result = 8'(BINARY_MAX);
      else
        format_result = v[7:0];
    end
  endfunction : format_result

  // Conversion sequencer: one conversion per interval, or one per
  // one-shot in standby. The range is latched at the start so a change
  // during a conversion only affects the next one.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_q <= IDLE;
      range_latched_q <= 1'b0;
      meas_left_q <= '0;
      meas_total_q <= '0;
      sum_q <= '0;
    end
    else
    begin
      unique case (state_q)
        IDLE:
        begin
          if ((!standby && interval_tick) || one_shot_q)
          begin
            state_q <= LAUNCH;
            range_latched_q <= config_q[CFG_RANGE_BIT];
            sum_q <= '0;
            if (rate_q[3:0] >= RATE_FIRST_UNAVERAGED)
            begin
              meas_left_q <= 5'h01;
              meas_total_q <= 5'h01;
            end
            else
            begin
              meas_left_q <= 5'(AVG_COUNT);
              meas_total_q <= 5'(AVG_COUNT);
            end
          end
        end
        // A done pulse seen outside WAIT_MEAS is ignored.
        LAUNCH:
          state_q <= WAIT_MEAS;
        WAIT_MEAS:
        begin
          if (MEAS_IN.done)
          begin
            sum_q <= sum_next;
            meas_left_q <= meas_left_q - 5'h01;
            if (meas_left_q == 5'h01)
              state_q <= IDLE;
            else
              state_q <= LAUNCH;
          end
        end
      endcase
    end
  end

  // A single request pulse for each measurement of the analogue path.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      MEAS_START <= 1'b0;
    else
      MEAS_START <= (state_q == LAUNCH);
  end

  // Only the sequencer writes the result; bus writes never reach it.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      temp_result_q <= RST_TEMP_RESULT;
    else if (state_q == WAIT_MEAS && MEAS_IN.done && meas_left_q == 5'h01)
    begin
      if (meas_total_q == 5'h01)
        temp_result_q <= format_result(MEAS_IN.deg,
                                       range_latched_q);
      else
        temp_result_q <= format_result(avg_deg,
                                       range_latched_q);
    end
  end

  // Pins are re-evaluated every cycle, standby or not, so a register
  // write shows on them one cycle later.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ALARM_PIN_N <= 1'b1;
      OVERTEMP_SHUTDOWN_N <= 1'b1;
    end
    else
    begin
      // In second-shutdown mode the mask bit has no effect.
      if (config_q[CFG_PIN_FUNC_BIT])
        ALARM_PIN_N <= ~HIGH_COND;
      else
        ALARM_PIN_N <= ~(ALERT_COND & ~config_q[CFG_MASK_BIT]);
      OVERTEMP_SHUTDOWN_N <= ~OVERTEMP_COND;
    end
  end

  // Status outputs for the limit logic outside.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CONV_BUSY <= 1'b0;
      RANGE_EXTENDED <= 1'b0;
    end
    else
    begin
      CONV_BUSY <= (state_q != IDLE);
      RANGE_EXTENDED <= config_q[CFG_RANGE_BIT];
    end
  end

endmodule : temp_result_config_regs

// file: tb/link_host.sv
// Serial host model presenting register bytes to the block.
`timescale 1ns/10ps
module link_host
  import temp_result_pkg::*;
(
  input wire logic clk,
  output logic link_clk,
  output link_byte_type link_byte
);
  // The byte clock stands low between bytes.
  initial
  begin
    link_clk = 1'b0;
    link_byte = '0;
  end

  // One byte per 400 ns; data is held well past the rise, then inverted.
  task automatic send(input logic first, input logic [7:0] data);
    link_byte = '{wr: 1'b1, first: first, data: data};
    @(negedge clk);
    link_clk = 1'b1;
    repeat (4) @(negedge clk);
    link_clk = 1'b0;
    repeat (2) @(negedge clk);
    link_byte = '{wr: 1'b0, first: ~first, data: ~data};
    @(negedge clk);
  endtask : send
endmodule : link_host

// file: tb/temp_result_chk.sv
// Port checker for the result and configuration block.
`timescale 1ns/10ps
module temp_result_chk
  import temp_result_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic LINK_CLK,
  input wire meas_type MEAS_IN,
  input wire logic [7:0] LINK_RDATA,
  input wire logic MEAS_START,
  input wire logic ALERT_COND,
  input wire logic HIGH_COND,
  input wire logic OVERTEMP_COND,
  input wire logic ALARM_PIN_N,
  input wire logic OVERTEMP_SHUTDOWN_N,
  input wire logic CONV_BUSY
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic [3:0] quiet_q;

  // Cycles since the last byte or measurement, saturating at 15.
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
      quiet_q <= 4'h0;
    else if (LINK_CLK || MEAS_IN.done)
      quiet_q <= 4'h0;
    else if (quiet_q != 4'hf)
      quiet_q <= quiet_q + 4'h1;

  a_start_pulse: assert property (MEAS_START |=> !MEAS_START)
    else $error("measurement request longer than one cycle");
  a_start_busy: assert property (MEAS_START |-> CONV_BUSY)
    else $error("measurement request outside a conversion");
  a_busy_start: assert property ($rose(CONV_BUSY) |-> MEAS_START)
    else $error("conversion began without a request");
  a_busy_end: assert property ($fell(CONV_BUSY) |-> $past(MEAS_IN.done, 2))
    else $error("conversion ended without a measurement");
  a_reset_vals: assert property ($rose(RST_N) |-> LINK_RDATA == 8'h00)
    else $error("read data not zero after reset");
  a_rdata_quiet: assert property (quiet_q == 4'hf |-> $stable(LINK_RDATA))
    else $error("read data moved without a cause");
  a_overtemp_pin: assert property ($past(RST_N)
    |-> OVERTEMP_SHUTDOWN_N == !$past(OVERTEMP_COND))
    else $error("shutdown pin does not follow its condition");
  a_alarm_quiet: assert property ($past(RST_N) && !$past(ALERT_COND)
    && !$past(HIGH_COND) |-> ALARM_PIN_N)
    else $error("shared pin low without a condition");
  c_start: cover property (MEAS_START);
  c_alarm: cover property ($fell(ALARM_PIN_N));
  c_quiet: cover property (quiet_q == 4'hf);
endmodule : temp_result_chk

bind temp_result_config_regs temp_result_chk i_temp_result_chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .LINK_CLK(LINK_CLK),
  .MEAS_IN(MEAS_IN), .LINK_RDATA(LINK_RDATA), .MEAS_START(MEAS_START),
  .ALERT_COND(ALERT_COND), .HIGH_COND(HIGH_COND),
  .OVERTEMP_COND(OVERTEMP_COND), .ALARM_PIN_N(ALARM_PIN_N),
  .OVERTEMP_SHUTDOWN_N(OVERTEMP_SHUTDOWN_N), .CONV_BUSY(CONV_BUSY));

// file: tb/temp_result_config_regs_tb.sv
// Self-checking bench for the result and configuration block.
`timescale 1ns/10ps
module temp_result_config_regs_tb
  import temp_result_pkg::*;
;
  logic ref_clk, rst_n, alert_cond, high_cond, ot_cond, link_clk;
  logic meas_start, alarm_n, ot_n, busy, rng_ext;
  logic b1 = 1'b0;
  logic [1:0] dly = 2'h0;
  logic [7:0] rdata;
  link_byte_type link_in;
  meas_type meas = '0;
  logic signed [MEAS_WIDTH-1:0] deg_in;
  int n_mismatch, checked, nf, ns, ns0;
  int deg_t [8] = '{25, -5, 150, 25, -55, 150, 200, -70};
  logic [7:0] exp_t [8] = '{8'h19, 8'h00, 8'h7f, 8'h59, 8'h09, 8'hd6,
    8'hff, 8'h00};

  temp_result_config_regs #(.CONV_PERIOD_CYC(4096)) i_temp_result_config_regs (
    .REF_CLK(ref_clk), .RST_N(rst_n), .LINK_CLK(link_clk),
    .LINK_IN(link_in), .LINK_RDATA(rdata), .MEAS_START(meas_start),
    .MEAS_IN(meas), .ALERT_COND(alert_cond), .HIGH_COND(high_cond),
    .OVERTEMP_COND(ot_cond), .ALARM_PIN_N(alarm_n),
    .OVERTEMP_SHUTDOWN_N(ot_n), .CONV_BUSY(busy), .RANGE_EXTENDED(rng_ext));
  link_host i_link_host (.clk(ref_clk), .link_clk(link_clk),
    .link_byte(link_in));

  // Free-running 20 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Measurement path answers after two cycles; conversions are counted.
  always @(negedge ref_clk)
  begin
    dly <= {dly[0], meas_start};
    meas <= '{done: dly[1], deg: deg_in};
    b1 <= busy;
    if (b1 && !busy)
      nf++;
    if (meas_start)
      ns++;
  end

  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    i_link_host.send(1'b1, addr);
    i_link_host.send(1'b0, data);
  endtask : wr

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    i_link_host.send(1'b1, addr);
    repeat (2) @(negedge ref_clk);
    check(rdata, exp);
  endtask : rd

  // Waits for n finished conversions; a hang ends the run.
  task automatic convs(input int n);
    int k;
    k = nf + n;
    for (int t = 0; t < 4000 && nf < k; t++)
      @(negedge ref_clk);
    if (nf < k)
    begin
      n_mismatch++;
      test_done();
    end
    @(negedge ref_clk);
  endtask : convs

  // Main sequence; reserved bits and rate codes are kept legal.
  initial
  begin
    rst_n = 1'b0;
    {alert_cond, high_cond, ot_cond} = 3'h0;
    deg_in = 10'sd25;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    check(rdata, RST_TEMP_RESULT);
    check({7'h0, rng_ext}, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      if (i == 3)
      begin
        wr(ADDR_CONFIG_WR, 8'h04);
        i_link_host.send(1'b1, ADDR_TEMP_RESULT);
      end
      deg_in = MEAS_WIDTH'(deg_t[i]);
      convs(2);
      check(rdata, exp_t[i]);
    end
    check({7'h0, rng_ext}, 8'h01);
    rd(ADDR_CONFIG_RD, 8'h04);
    rd(ADDR_RATE_RD, RST_RATE);
    convs(1);
    ns0 = ns;
    repeat (48) @(negedge ref_clk);
    check(8'(ns - ns0), 8'h03);
    wr(ADDR_RATE_WR, 8'h07);
    rd(ADDR_RATE_RD, 8'h07);
    convs(1);
    ns0 = ns;
    convs(1);
    check(8'(ns - ns0), 8'h10);
    wr(ADDR_RATE_WR, 8'h08);
    wr(ADDR_CONFIG_WR, 8'h40);
    repeat (100) @(negedge ref_clk);
    ns0 = ns;
    repeat (64) @(negedge ref_clk);
    check(8'(ns - ns0), 8'h00);
    rd(ADDR_CONFIG_RD, 8'h40);
    // No conversion runs in standby, so a landed write would stay visible.
    wr(ADDR_TEMP_RESULT, 8'h55);
    check(rdata, 8'h00);
    wr(ADDR_ONE_SHOT, 8'h00);
    repeat (20) @(negedge ref_clk);
    check(8'(ns - ns0), 8'h01);
    alert_cond = 1'b1;
    ot_cond = 1'b1;
    repeat (2) @(negedge ref_clk);
    check({6'h0, alarm_n, ot_n}, 8'h00);
    wr(ADDR_CONFIG_WR, 8'hc0);
    check({7'h0, alarm_n}, 8'h01);
    wr(ADDR_CONFIG_WR, 8'he0);
    check({7'h0, alarm_n}, 8'h01);
    high_cond = 1'b1;
    repeat (2) @(negedge ref_clk);
    check({7'h0, alarm_n}, 8'h00);
    test_done();
  end
endmodule : temp_result_config_regs_tb
